// ### hdl/ums_regs.vh
// Register map, field positions, reset values and codes for the UART
// handshake status, FIFO control and interrupt identification block.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
`ifndef UMS_REGS_VH
`define UMS_REGS_VH

// Byte offsets, one word each
`define UMS_OFF_HS_CTRL     4'h0
`define UMS_OFF_HS_STATUS   4'h4
`define UMS_OFF_FIFO_CTRL   4'h8
`define UMS_OFF_INT_IDENT   4'hc

// Handshake control fields
`define UMS_HC_DTR          0
`define UMS_HC_RTS          1
`define UMS_HC_LOOP_RI      2
`define UMS_HC_IRQ_EN       3
`define UMS_HC_LOOPBACK     4
`define UMS_HC_RESET        5'h00

// FIFO control fields
`define UMS_FC_ENABLE       0
`define UMS_FC_RX_RESET     1
`define UMS_FC_TX_RESET     2
`define UMS_FC_DMA_SEL      3
`define UMS_FC_LEVEL_LO     6
`define UMS_FC_LEVEL_HI     7

// Receive interrupt active levels in bytes
`define UMS_LEVEL_0         5'h01
`define UMS_LEVEL_1         5'h04
`define UMS_LEVEL_2         5'h08
`define UMS_LEVEL_3         5'h0e

// Interrupt identification codes, bits 3:0
`define UMS_ID_NONE         4'h1
`define UMS_ID_LINE         4'h6
`define UMS_ID_RX_DATA      4'h4
`define UMS_ID_TIMEOUT      4'hc
`define UMS_ID_TX_EMPTY     4'h2
`define UMS_ID_MODEM        4'h0

// AXI responses
`define UMS_RESP_OKAY       2'b00
`define UMS_RESP_SLVERR     2'b10

`endif

// ### hdl/ums_uart_modem_fifo.v
// UART handshake status, FIFO control and interrupt identification.
// Assumes synchronous modem pins (active low) and AXI4-Lite register access.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ums_regs.vh"

module ums_uart_modem_fifo #(
    parameter CNT_W = 5                    // Receive FIFO count width
) (
    input  wire             aclk,
    input  wire             aresetn,
    // AXI4-Lite slave
    input  wire [3:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output wire             s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output wire             s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [3:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output wire             s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    // Modem pins, active low
    input  wire             dcd_n,
    input  wire             ri_n,
    input  wire             dsr_n,
    input  wire             cts_n,
    output reg              rts_n,
    output reg              dtr_n,
    // Interrupt sources from the rest of the UART
    input  wire             line_status_int,
    input  wire             rx_data_ready,
    input  wire [CNT_W-1:0] rx_fifo_count,
    input  wire             rx_timeout,
    input  wire             tx_empty_int,
    // Controls to the rest of the UART
    output reg              fifo_enable,
    output reg              dma_mode,
    output reg              tx_fifo_reset,
    output reg              rx_fifo_reset,
    output reg              loopback,
    output reg              irq_enable,
    output reg              rx_level_reached,
    output reg              tx_empty_ack,
    output reg              int_pending
);

    // Stored control state
    reg [4:0] hs_ctrl;                     // Handshake control bits 4:0
    reg [1:0] rx_level_sel;                // Receive active level select
    reg       dma_sel;                     // DMA mode select bit
    reg [3:0] change_flags;                // Sticky change flags 3:0
    reg [3:0] prev_modem;                  // Last modem state, 7:4 order

    // Write channel holding registers
    // Either channel may arrive first; each is parked until the other
    reg       aw_held;                     // Write address captured
    reg       w_held;                      // Write data captured
    reg [3:0] aw_addr;                     // Captured write address
    reg [7:0] w_byte;                      // Captured low data byte
    reg       w_lane0;                     // Low byte lane enabled

    // Combinational views
    // Decoded every cycle from the stored state and the pins
    reg [3:0] modem_now;                   // Effective modem bits 7:4
    reg [3:0] next_flags;                  // Flags after set and clear
    reg [4:0] rx_level;                    // Active level in bytes
    reg [3:0] ident_code;                  // Interrupt ident bits 3:0
    reg [7:0] ident_byte;                  // Full ident register value
    reg [7:0] rd_byte;                     // Read data for the address
    reg       rd_hit;                      // Read address is mapped

    wire      do_write;                    // Both halves held, commit
    wire      rd_take;                     // Read address handshake
    wire      status_read;                 // Status register is read
    wire      modem_int;                   // Modem status interrupt
    wire      rx_data_int;                 // Receive data interrupt

    wire [31:0] level_wide;                // Active level, zero extended
    wire [31:0] count_wide;                // FIFO count, zero extended

    // Both sides of the level compare share one fixed width, so any
    // count width below 32 works without a zero-length replication
    assign level_wide = {27'h0, rx_level};
    assign count_wide = {{(32-CNT_W){1'b0}}, rx_fifo_count};

    // One write in flight; both channels stall while the answer waits.
    // The answer comes one edge after the channels are taken, since
    // the commit waits for both halves to be held in registers.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign rd_take       = s_axi_arvalid && !s_axi_rvalid;
    assign status_read   = rd_take &&
                           (s_axi_araddr == `UMS_OFF_HS_STATUS);

    // Effective modem bits: pins inverted or looped back control
    // In loopback the pins are ignored, so a modem that keeps toggling
    // cannot disturb a diagnostic run
    always @* begin
        if (hs_ctrl[`UMS_HC_LOOPBACK]) begin
            modem_now[3] = hs_ctrl[`UMS_HC_IRQ_EN];
            modem_now[2] = hs_ctrl[`UMS_HC_LOOP_RI];
            modem_now[1] = hs_ctrl[`UMS_HC_DTR];
            modem_now[0] = hs_ctrl[`UMS_HC_RTS];
        end else begin
            modem_now[3] = ~dcd_n;
            modem_now[2] = ~ri_n;
            modem_now[1] = ~dsr_n;
            modem_now[0] = ~cts_n;
        end
    end

    // Flag update: a read clears, a change in the same cycle still sets
    // Letting the set win means no edge is lost when software reads
    // at the moment the pin moves
    always @* begin
        next_flags = status_read ? 4'h0 : change_flags;
        if (modem_now[3] != prev_modem[3])
            next_flags[3] = 1'b1;
        // Ring pin low-to-high means the inverted bit falls
        if (prev_modem[2] && !modem_now[2])
            next_flags[2] = 1'b1;
        if (modem_now[1] != prev_modem[1])
            next_flags[1] = 1'b1;
        if (modem_now[0] != prev_modem[0])
            next_flags[0] = 1'b1;
    end

    // Receive active level from the select bits
    // The select bits store and drive rx_level_reached with FIFOs off; only the data interrupt ignores them then
    always @* begin
        case (rx_level_sel)
            2'b00:   rx_level = `UMS_LEVEL_0;
            2'b01:   rx_level = `UMS_LEVEL_1;
            2'b10:   rx_level = `UMS_LEVEL_2;
            2'b11:   rx_level = `UMS_LEVEL_3;
            default: rx_level = `UMS_LEVEL_0;
        endcase
    end

    // In FIFO mode data interrupts wait for the level, else any byte
    // The level flag is registered, so a data interrupt lags a cycle
    assign rx_data_int = fifo_enable ? rx_level_reached : rx_data_ready;
    assign modem_int   = |change_flags;

    // Priority encoder, highest source first
    // Time-out is only reported in FIFO mode, where bit 3 may be set;
    // in byte mode that source is simply ignored
    always @* begin
        if (line_status_int)
            ident_code = `UMS_ID_LINE;
        else if (rx_data_int)
            ident_code = `UMS_ID_RX_DATA;
        else if (rx_timeout && fifo_enable)
            ident_code = `UMS_ID_TIMEOUT;
        else if (tx_empty_int)
            ident_code = `UMS_ID_TX_EMPTY;
        else if (modem_int)
            ident_code = `UMS_ID_MODEM;
        else
            ident_code = `UMS_ID_NONE;
        ident_byte = {fifo_enable, fifo_enable, 2'b00, ident_code};
    end

    // Read data mux; reserved bits read as zero
    // Unmapped offsets answer with an error and read as zero
    always @* begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr)
            `UMS_OFF_HS_CTRL:   rd_byte = {3'b000, hs_ctrl};
            `UMS_OFF_HS_STATUS: rd_byte = {modem_now, change_flags};
            // Reset bits always read back as zero since they self clear
            `UMS_OFF_FIFO_CTRL: rd_byte = {rx_level_sel, 2'b00,
                                           dma_sel, 2'b00, fifo_enable};
            `UMS_OFF_INT_IDENT: rd_byte = ident_byte;
            default:            rd_hit  = 1'b0;
        endcase
    end

    // Write channels may arrive in either order; hold each until both
    // Writes to the read-only registers are refused with an error and
    // leave every stored bit alone
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 4'h0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UMS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Only the two writable offsets answer OKAY
                if (aw_addr == `UMS_OFF_HS_CTRL ||
                    aw_addr == `UMS_OFF_FIFO_CTRL)
                    s_axi_bresp <= `UMS_RESP_OKAY;
                else
                    s_axi_bresp <= `UMS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; reset strobes last exactly one cycle
    // Fields store whether or not the FIFOs are on; putting the enable
    // first is left to software
    always @(posedge aclk) begin
        if (!aresetn) begin
            hs_ctrl       <= `UMS_HC_RESET;
            rx_level_sel  <= 2'b00;
            dma_sel       <= 1'b0;
            fifo_enable   <= 1'b0;
            tx_fifo_reset <= 1'b0;
            rx_fifo_reset <= 1'b0;
        end else begin
            tx_fifo_reset <= 1'b0;
            rx_fifo_reset <= 1'b0;
            if (do_write && w_lane0) begin
                if (aw_addr == `UMS_OFF_HS_CTRL)
                    hs_ctrl <= w_byte[4:0];
                if (aw_addr == `UMS_OFF_FIFO_CTRL) begin
                    fifo_enable   <= w_byte[`UMS_FC_ENABLE];
                    dma_sel       <= w_byte[`UMS_FC_DMA_SEL];
                    rx_level_sel  <= w_byte[`UMS_FC_LEVEL_HI:
                                            `UMS_FC_LEVEL_LO];
                    tx_fifo_reset <= w_byte[`UMS_FC_TX_RESET];
                    rx_fifo_reset <= w_byte[`UMS_FC_RX_RESET];
                end
            end
        end
    end

    // Read answer is registered one cycle after the address is taken
    // The status read that clears the flags returns their values from
    // before the clear, so no change is reported twice or lost
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `UMS_RESP_OKAY;
            tx_empty_ack <= 1'b0;
        end else begin
            tx_empty_ack <= 1'b0;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? `UMS_RESP_OKAY
                                       : `UMS_RESP_SLVERR;
                // Reading ident while transmit-empty is shown clears it
                tx_empty_ack <= (s_axi_araddr == `UMS_OFF_INT_IDENT) &&
                                (ident_code == `UMS_ID_TX_EMPTY);
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Change tracking; after reset the first sample is compared against the reset history
    // History resets to the idle level of the pins, so an input already
    // asserted when reset ends, except ring, flags one change
    always @(posedge aclk) begin
        if (!aresetn) begin
            change_flags <= 4'h0;
            prev_modem   <= 4'h0;
        end else begin
            prev_modem   <= modem_now;
            change_flags <= next_flags;
        end
    end

    // Registered outputs to pins and the rest of the UART
    // All of these lag the stored bits by one cycle; every output here is a
    // flip-flop at the cost of that latency
    always @(posedge aclk) begin
        if (!aresetn) begin
            rts_n            <= 1'b1;
            dtr_n            <= 1'b1;
            loopback         <= 1'b0;
            irq_enable       <= 1'b0;
            dma_mode         <= 1'b0;
            rx_level_reached <= 1'b0;
            int_pending      <= 1'b0;
        end else begin
            // Outputs go inactive in loopback so the line sees nothing
            rts_n      <= ~hs_ctrl[`UMS_HC_RTS] |
                          hs_ctrl[`UMS_HC_LOOPBACK];
            dtr_n      <= ~hs_ctrl[`UMS_HC_DTR] |
                          hs_ctrl[`UMS_HC_LOOPBACK];
            loopback   <= hs_ctrl[`UMS_HC_LOOPBACK];
            irq_enable <= hs_ctrl[`UMS_HC_IRQ_EN];
            dma_mode   <= dma_sel & fifo_enable;
            // Level reached once the held count meets the chosen level
            rx_level_reached <= (level_wide <= count_wide);
            int_pending <= (ident_code != `UMS_ID_NONE);
        end
    end

endmodule
`default_nettype wire

// ### bench/ums_modem_model.sv
// Modem peer model facing the handshake pins of the block.
// Assumes active-low pins on one clock; carrier and ring come from the bench.
`timescale 1ns/1ns
`default_nettype none
module ums_modem_model (
    input  wire logic aclk,
    input  wire logic rts_n,
    input  wire logic dtr_n,
    input  wire logic dcd_on,  // Carrier asserted on command
    input  wire logic ri_on,   // Ringing asserted on command
    input  wire logic slow,    // Echo after five cycles instead of one
    output var  logic dcd_n,
    output var  logic ri_n,
    output var  logic dsr_n,
    output var  logic cts_n
);
    logic [3:0] dl;            // Delay line for the ready echo
    logic [3:0] rl;            // Delay line for the send echo
    initial begin
        {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
        dl = 4'hf;
        rl = 4'hf;
    end
    // A modem echoes terminal ready and send request; a slow one lags
    always @(posedge aclk) begin
        dl <= {dl[2:0], dtr_n};
        rl <= {rl[2:0], rts_n};
        dsr_n <= slow ? dl[3] : dtr_n;
        cts_n <= slow ? rl[3] : rts_n;
        dcd_n <= ~dcd_on;
        ri_n <= ~ri_on;
    end
endmodule
`default_nettype wire

// ### bench/ums_checker_properties.sv
// Concurrent checks on the ports of the handshake and FIFO control block.
// Assumes the master offers write address and data in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module ums_checker #(
    parameter CNT_W = 5
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic [3:0]       s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic [31:0]      s_axi_wdata,
    input wire logic [3:0]       s_axi_wstrb,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             rts_n,
    input wire logic             dtr_n,
    input wire logic             loopback,
    input wire logic             fifo_enable,
    input wire logic             dma_mode,
    input wire logic             tx_fifo_reset,
    input wire logic             rx_fifo_reset,
    input wire logic             rx_level_reached,
    input wire logic [CNT_W-1:0] rx_fifo_count,
    input wire logic             line_status_int,
    input wire logic             int_pending
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       wr_both;  // Address and data taken together
    logic       wr_fc;    // Enabled write to FIFO control
    logic [1:0] lvl_q;    // Shadow of the active level field
    logic [4:0] lvl_b;    // Active level in bytes
    logic       lvl_hit;  // Level reached, one cycle late like the port
    logic       fc_go;    // FIFO control write waiting to commit
    logic [1:0] fc_lvl;   // Level field of that write
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                     && s_axi_wready;
    assign wr_fc = wr_both && s_axi_awaddr == 4'h8 && s_axi_wstrb[0];
    assign lvl_b = lvl_q == 2'h0 ? 5'h01 : lvl_q == 2'h1 ? 5'h04 :
                   lvl_q == 2'h2 ? 5'h08 : 5'h0e;
    // Shadow tracks the stored field so the compare needs no register read
    always @(posedge aclk) begin
        if (!aresetn) begin
            lvl_q <= 2'h0;
            fc_go <= 1'b0;
            fc_lvl <= 2'h0;
            lvl_hit <= 1'b0;
        end else begin
            // The design commits a write one edge after taking it
            fc_go <= wr_fc;
            fc_lvl <= s_axi_wdata[7:6];
            if (fc_go) lvl_q <= fc_lvl;
            lvl_hit <= 32'(rx_fifo_count) >= 32'(lvl_b);
        end
    end
    sequence s_fc_write;
        wr_fc;
    endsequence
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    chk_loop_quiets: assert property (
        loopback && $past(loopback) |-> rts_n && dtr_n)
        else $error("modem outputs active in loopback");
    chk_dma_gated: assert property (
        dma_mode |-> fifo_enable || $past(fifo_enable))
        else $error("dma mode without fifo enable");
    chk_txrst_pulse: assert property (
        s_fc_write ##0 s_axi_wdata[2] |-> ##2 s_pulse(tx_fifo_reset))
        else $error("transmit reset not a single pulse");
    chk_rxrst_pulse: assert property (
        s_fc_write ##0 s_axi_wdata[1] |-> ##2 s_pulse(rx_fifo_reset))
        else $error("receive reset not a single pulse");
    chk_level_hit: assert property (
        rx_level_reached == lvl_hit)
        else $error("level reached flag wrong");
    chk_fifo_store: assert property (
        s_fc_write |-> ##2 fifo_enable == $past(s_axi_wdata[0], 2))
        else $error("fifo enable not stored");
    chk_line_pend: assert property (
        line_status_int |-> ##[1:2] int_pending)
        else $error("line status not pending");
    chk_write_answer: assert property (
        wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
endmodule
bind ums_uart_modem_fifo ums_checker #(.CNT_W(CNT_W)) u_chk (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .rts_n, .dtr_n, .loopback,
    .fifo_enable, .dma_mode, .tx_fifo_reset, .rx_fifo_reset, .rx_level_reached,
    .rx_fifo_count, .line_status_int, .int_pending);
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the handshake status and FIFO control block.
// Assumes the modem peer model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        aclk, aresetn;
    logic [3:0]  awaddr, araddr, wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic        dcd_n, ri_n, dsr_n, cts_n, rts_n, dtr_n;
    logic        dcd_on, ri_on, slow;  // Peer model commands
    logic [3:0]  src;                  // Line, rx ready, time-out, tx empty
    logic [4:0]  cnt;                  // Receive FIFO fill
    logic        fen, dma, lvl, irq, lpb, ack;
    int          bad_count = 0, n_tests = 0, cyc = 0, n_ack = 0;
    ums_uart_modem_fifo dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dcd_n(dcd_n),
        .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n),
        .line_status_int(src[3]), .rx_data_ready(src[2]), .rx_fifo_count(cnt),
        .rx_timeout(src[1]), .tx_empty_int(src[0]), .fifo_enable(fen),
        .dma_mode(dma), .tx_fifo_reset(), .rx_fifo_reset(), .loopback(lpb),
        .irq_enable(irq), .rx_level_reached(lvl), .tx_empty_ack(ack),
        .int_pending());
    ums_modem_model peer (.aclk(aclk), .rts_n(rts_n), .dtr_n(dtr_n),
        .dcd_on(dcd_on), .ri_on(ri_on), .slow(slow), .dcd_n(dcd_n),
        .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Counts transmit-empty acknowledge pulses
    always @(posedge aclk) if (ack) n_ack <= n_ack + 1;
    // A hung handshake ends the run here
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time,
                     what, got, exp);
            bad_count++;
        end
    endtask
    // Handshakes are sampled mid-cycle, where they equal the next edge
    task automatic axw(input logic [3:0] a, input logic [7:0] v,
                       input logic [3:0] s, output logic [1:0] rs);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] v,
                       output logic [1:0] rs);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            axr(4'(4 * i), d, r);
            chk(d, (i == 3) ? 32'h1 : 32'h0, "reset value");
        end
        chk({rts_n, dtr_n}, 2'h3, "idle outputs");
        $display("test reset done");
    endtask
    task automatic t_bus;
        axw(4'h4, 8'hff, 4'h1, r);
        chk(r, 2'h2, "status write refused");
        axw(4'hc, 8'hff, 4'h1, r);
        chk(r, 2'h2, "ident write refused");
        axw(4'h0, 8'h1f, 4'h0, r);
        axr(4'h0, d, r);
        chk(d, 32'h0, "masked write dropped");
        $display("test bus done");
    endtask
    // Pin changes and loopback mirroring, each step read back and cleared
    task automatic t_modem;
        logic [7:0] mc [8] = '{8'h01, 8'h03, 8'h03, 8'h1f, 8'h12, 8'h19,
                               8'h14, 8'h00};
        logic [1:0] md [8] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
        logic [7:0] ms [8] = '{8'h22, 8'hf9, 8'hb4, 8'hf0, 8'h1e, 8'hab,
                               8'h4a, 8'h8c};
        for (int i = 0; i < 8; i++) begin
            slow <= i[0];
            {dcd_on, ri_on} <= md[i];
            axw(4'h0, mc[i], 4'h1, r);
            repeat (10) @(posedge aclk);
            chk({rts_n, dtr_n, irq, lpb},
                {mc[i][4] ? 2'h3 : ~mc[i][1:0], mc[i][3], mc[i][4]}, "pins");
            axr(4'hc, d, r);
            chk(d, (ms[i][3:0] != 4'h0) ? 32'h0 : 32'h1, "modem id");
            axr(4'h4, d, r);
            chk(d, {24'h0, ms[i]}, "status");
        end
        $display("test modem done");
    endtask
    // Active levels at their boundaries, then every priority code but modem status
    task automatic t_fifo;
        logic [7:0] ff [15] = '{8'h01, 8'h01, 8'h41, 8'h41, 8'h81, 8'h81,
            8'hc1, 8'hc9, 8'hcf, 8'hc1, 8'hc1, 8'h31, 8'h00, 8'h08, 8'h00};
        logic [3:0] fs [15] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
            4'h0, 4'h1, 4'hf, 4'h2, 4'h4, 4'h2, 4'h4, 4'h1};
        logic [4:0] fc [15] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h07, 5'h08,
            5'h0d, 5'h0e, 5'h00, 5'h0e, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
        logic [7:0] fi [15] = '{8'hc1, 8'hc4, 8'hc1, 8'hc4, 8'hc1, 8'hc4,
            8'hc1, 8'hc4, 8'hc2, 8'hc6, 8'hcc, 8'hc1, 8'h01, 8'h04, 8'h02};
        logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
        for (int i = 0; i < 15; i++) begin
            src <= fs[i];
            cnt <= fc[i];
            axw(4'h8, ff[i], 4'h1, r);
            repeat (3) @(posedge aclk);
            chk({fen, dma, lvl}, {ff[i][0], ff[i][0] & ff[i][3],
                fc[i] >= lv[ff[i][7:6]]}, "fifo outputs");
            axr(4'h8, d, r);
            chk(d, {24'h0, ff[i] & 8'hc9}, "fifo control");
            axr(4'hc, d, r);
            chk(d, {24'h0, fi[i]}, "ident");
        end
        @(posedge aclk);
        chk(n_ack, 2, "transmit empty acks");
        $display("test fifo done");
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        {dcd_on, ri_on, slow, src, cnt} = 12'h000;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bus();
        t_modem();
        t_fifo();
        end_sim();
    end
endmodule
`default_nettype wire
